// [test/irqf_chk.sv]
// Checker: bus and request properties at the flag block ports
`timescale 1ns/1ps
`default_nettype none
module irqf_chk
    import irqf_pkg::*;
(
    input wire logic                   core_clk,
    input wire logic                   reset_n,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [IRQF_ADDR_W-1:0] paddr,
    input wire logic [IRQF_DATA_W-1:0] prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   irq_req,
    input wire logic [IRQF_VEC_W-1:0]  irq_vector,
    input wire logic                   irq_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire logic mapped = paddr inside {12'h220, 12'h260, 12'h370, 12'h384,
                                      12'h400, 12'h404, 12'h408, 12'h40C};
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence
    a_zero_wait: assert property (s_access |-> pready)
        else $error("access without ready");
    a_unmapped_err: assert property (s_access ##0 (!mapped && !pwrite) |->
        pslverr && prdata == RDATA_ZERO) else $error("unmapped read not refused");
    a_mapped_ok: assert property (s_access ##0 mapped |-> !pslverr)
        else $error("mapped access refused");
    a_read_hold: assert property (!$stable(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved outside a read");
    a_idle_vec: assert property (!irq_req |-> irq_vector == VEC_RESET)
        else $error("vector without request");
    a_vec_not_reset: assert property (irq_req |-> irq_vector != VEC_RESET)
        else $error("request points at reset address");
    a_rst_quiet: assert property ($rose(reset_n) |-> !irq_req && !irq_out)
        else $error("request right after reset");
    a_out_fall_cause: assert property ($fell(irq_out) |-> $past(psel && penable))
        else $error("interrupt line fell without access");
    // Read setup must be visible in every run, or the hold check proves nothing
    c_read: cover property (s_rd_setup);
endmodule
bind irqf_top irqf_chk i_chk (
    .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .irq_req, .irq_vector, .irq_out
);
`default_nettype wire

// [test/irqf_core_model.sv]
// Processor core model: takes the reset address and interrupt vectors
`timescale 1ns/1ps
`default_nettype none
module irqf_core_model
    import irqf_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    output logic      [15:0] fetch_addr
);
    // Only the combined request is seen, so enables must gate it upstream
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_addr <= VEC_RESET;
        end else if (irq_req) begin
            fetch_addr <= irq_vector;
        end
    end
endmodule
`default_nettype wire

// [test/tb_interrupt_request_flags.sv]
// Testbench: register, flag and vector checks of the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_request_flags
    import irqf_pkg::*;
;
    localparam logic [11:0] A_TE = {IDX_TIMER_EXT_IRQ_FLAGS, 2'h0};
    localparam logic [11:0] A_SC = {IDX_SERIAL_PORT_CONTROL, 2'h0};
    localparam logic [11:0] A_TW = {IDX_TWOWIRE_CONTROL, 2'h0};
    localparam logic [11:0] A_SP = {IDX_SPI_STATUS, 2'h0};
    localparam logic [11:0] A_EN = {IDX_IRQ_ENABLE, 2'h0};
    localparam logic [11:0] A_ST = {IDX_EVENT_STATUS, 2'h0};
    localparam logic [11:0] A_MK = {IDX_EVENT_MASK, 2'h0};
    logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic        uart_mode0, adc_pending, irq_req, irq_out, ext_irq0_pin, ext_irq1_pin;
    logic [3:0]  pstrb;
    logic [7:0]  st;
    logic [9:0]  ev;
    logic [11:0] paddr;
    logic [15:0] irq_vector, fetch_addr;
    logic [31:0] pwdata, prdata, rd, d;
    int          n_errors, tests_run;
    // Vector parameter defaults, in priority order
    logic [15:0] vtab [8] = '{16'h0003, VEC_TIMER0, VEC_EXT1, 16'h001B,
                              16'h0023, 16'h004B, 16'h0043, VEC_ADC};
    logic [11:0] regs [7] = '{A_TE, A_SC, A_TW, A_SP, A_EN, A_ST, A_MK};
    irqf_top i_dut (
        .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .timer0_overflow(ev[0]), .timer1_overflow(ev[1]),
        .ext_irq0_pin, .ext_irq1_pin, .uart_mode0, .uart_tx_bit8_end(ev[2]),
        .uart_tx_stop_begin(ev[3]), .uart_rx_bit8_end(ev[4]), .uart_rx_stop_mid(ev[5]),
        .spi_xfer_end(ev[6]), .spi_fault_event(ev[7]), .spi_data_reg_read(ev[8]),
        .twowire_state(st), .twowire_state_enter(ev[9]), .adc_pending, .irq_req,
        .irq_vector, .irq_out
    );
    irqf_core_model i_core (.core_clk, .reset_n, .irq_req, .irq_vector, .fetch_addr);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge core_clk);
        penable <= 1'h1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string s);
        apb(1'h0, a, 32'h0);
        chk(rd & 32'hFF, e, s);
    endtask
    task automatic pulse(input int b);
        @(posedge core_clk);
        ev[b] <= 1'h1;
        @(posedge core_clk);
        ev <= 10'h000;
    endtask
    function automatic logic [15:0] exp_vec(input logic [7:0] p);
        for (int i = 0; i < 8; i++) begin
            if (p[i]) begin
                return vtab[i];
            end
        end
        return VEC_RESET;
    endfunction
    task automatic vchk(input logic [7:0] p);
        repeat (3) @(posedge core_clk);
        #1;
        chk({31'h0, irq_req}, {31'h0, p != 8'h00}, "request");
        chk({16'h0, irq_vector}, {16'h0, exp_vec(p)}, "vector");
        if (p != 8'h00) begin
            chk({16'h0, fetch_addr}, {16'h0, exp_vec(p)}, "fetch");
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, psel, penable, pwrite, uart_mode0, adc_pending} = 6'h00;
        {ext_irq0_pin, ext_irq1_pin} = 2'h3;
        {pstrb, st, ev, paddr, pwdata} = {4'hF, 62'h0};
        n_errors = 0;
        tests_run = 0;
        d = $urandom(50480);
        repeat (4) @(posedge core_clk);
        reset_n <= 1'h1;
        foreach (regs[i]) rdchk(regs[i], 32'h0, "reset value");
        chk({16'h0, fetch_addr}, {16'h0, VEC_RESET}, "reset fetch");
        $display("test reset done");
        pulse(0);
        pulse(1);
        {ext_irq0_pin, ext_irq1_pin} <= 2'h0;
        repeat (6) @(posedge core_clk);
        rdchk(A_TE, 32'hAA, "timer ext flags");
        {ext_irq0_pin, ext_irq1_pin} <= 2'h3;
        d = $urandom;
        apb(1'h1, A_TE, d);
        apb(1'h0, A_TE, 32'h0);
        chk(rd & 32'hAA, d & 32'hAA, "flag write");
        apb(1'h1, A_TE, 32'h0);
        $display("test timer and pin flags done");
        // Each strobe sets its flag only in the matching mode, and it stays set
        for (int m = 0; m < 2; m++) begin
            uart_mode0 <= m[0];
            for (int s = 2; s < 6; s++) begin
                pulse(s);
                repeat (20) @(posedge core_clk);
                rdchk(A_SC, (s[0] ^ m[0]) ? (s < 4 ? 32'h2 : 32'h1) : 32'h0, "uart");
                apb(1'h1, A_SC, 32'h0);
            end
        end
        $display("test uart done");
        pulse(6);
        rdchk(A_SP, 32'h80, "spi done");
        apb(1'h1, A_SP, 32'h0);
        rdchk(A_SP, 32'h80, "spi read only");
        pulse(8);
        rdchk(A_SP, 32'h0, "spi cleared");
        pulse(6);
        pulse(8);
        rdchk(A_SP, 32'h80, "data read alone");
        pulse(8);
        rdchk(A_SP, 32'h0, "spi cleared again");
        pulse(7);
        rdchk(A_SP, 32'h10, "mode fault");
        rdchk(A_SP, 32'h0, "mode fault cleared by read");
        $display("test spi done");
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            st <= (i == 0) ? TW_NO_INFO_STATE : d[7:0];
            d = (i == 0 || d[7:0] == TW_NO_INFO_STATE) ? 32'h0 : 32'h80;
            pulse(9);
            rdchk(A_TW, d, "twowire set");
            apb(1'h1, A_TW, 32'hFF);
            rdchk(A_TW, d, "twowire write one");
            apb(1'h1, A_TW, 32'h0);
            rdchk(A_TW, 32'h0, "twowire write zero");
        end
        $display("test twowire done");
        rdchk(A_ST, 32'h7F, "event status");
        rdchk(A_ST, 32'h0, "status read clear");
        apb(1'h1, A_MK, 32'h02);
        apb(1'h1, A_EN, 32'hFF);
        pulse(0);
        ext_irq1_pin <= 1'h0;
        repeat (6) @(posedge core_clk);
        vchk(8'h06);
        chk({31'h0, irq_out}, 32'h1, "masked line high");
        apb(1'h0, {IDX_REQUEST_INFO, 2'h0}, 32'h0);
        chk(rd & 32'hFFFF01FF, {VEC_TIMER0, 16'h0106}, "request info");
        rdchk(A_ST, 32'h06, "event status");
        @(posedge core_clk);
        #1;
        chk({31'h0, irq_out}, 32'h0, "line cleared");
        ext_irq1_pin <= 1'h1;
        apb(1'h1, A_EN, 32'hFD);
        vchk(8'h04);
        apb(1'h1, A_EN, 32'h00);
        vchk(8'h00);
        apb(1'h1, A_TE, 32'h0);
        adc_pending <= 1'h1;
        apb(1'h1, A_EN, 32'h80);
        vchk(8'h80);
        adc_pending <= 1'h0;
        apb(1'h0, 12'hFFC, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        $display("test interrupts and vectors done");
        report_and_stop();
    end
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// [verilog/irqf_pkg.sv]
// Package: register map, bit positions and vector addresses of the interrupt flag block
`default_nettype none
package irqf_pkg;

    localparam int unsigned IRQF_ADDR_W   = 12;
    localparam int unsigned IRQF_DATA_W   = 32;
    localparam int unsigned IRQF_REG_W    = 8;
    localparam int unsigned IRQF_IDX_W    = 10;
    localparam int unsigned IRQF_VEC_W    = 16;
    localparam int unsigned IRQF_NSRC     = 8;

    // Register indexes; byte address is four times the index
    localparam logic [9:0] IDX_TIMER_EXT_IRQ_FLAGS = 10'h088;
    localparam logic [9:0] IDX_SERIAL_PORT_CONTROL = 10'h098;
    localparam logic [9:0] IDX_TWOWIRE_CONTROL     = 10'h0DC;
    localparam logic [9:0] IDX_SPI_STATUS          = 10'h0E1;
    localparam logic [9:0] IDX_IRQ_ENABLE          = 10'h100;
    localparam logic [9:0] IDX_EVENT_STATUS        = 10'h101;
    localparam logic [9:0] IDX_EVENT_MASK          = 10'h102;
    localparam logic [9:0] IDX_REQUEST_INFO        = 10'h103;

    // Bit positions inside the flag registers
    localparam int unsigned BIT_TIMER1    = 7;
    localparam int unsigned BIT_TIMER0    = 5;
    localparam int unsigned BIT_EXT1      = 3;
    localparam int unsigned BIT_EXT0      = 1;
    localparam int unsigned BIT_UART_TX   = 1;
    localparam int unsigned BIT_UART_RX   = 0;
    localparam int unsigned BIT_SPI_DONE  = 7;
    localparam int unsigned BIT_SPI_FAULT = 4;
    localparam int unsigned BIT_TW_FLAG   = 7;

    // Source numbering, also the layout of enable, event status and mask
    localparam int unsigned SRC_EXT0    = 0;
    localparam int unsigned SRC_TIMER0  = 1;
    localparam int unsigned SRC_EXT1    = 2;
    localparam int unsigned SRC_TIMER1  = 3;
    localparam int unsigned SRC_UART    = 4;
    localparam int unsigned SRC_SPI     = 5;
    localparam int unsigned SRC_TWOWIRE = 6;
    localparam int unsigned SRC_ADC     = 7;

    localparam logic [7:0]  TW_NO_INFO_STATE = 8'hF8;
    localparam logic [15:0] VEC_RESET        = 16'h0000;
    localparam logic [15:0] VEC_TIMER0       = 16'h000B;
    localparam logic [15:0] VEC_EXT1         = 16'h0013;
    localparam logic [15:0] VEC_ADC          = 16'h008B;

    localparam logic [7:0]  REG_RESET        = 8'h00;
    localparam logic [31:0] RDATA_ZERO       = 32'h0000_0000;

endpackage
`default_nettype wire

// [verilog/irqf_top.sv]
// Interrupt request flags with APB register access and vector selection
`timescale 1ns/1ps
`default_nettype none
module irqf_top
    import irqf_pkg::*;
#(
    parameter logic [15:0] VEC_EXT0    = 16'h0003,
    parameter logic [15:0] VEC_TIMER1  = 16'h001B,
    parameter logic [15:0] VEC_UART    = 16'h0023,
    parameter logic [15:0] VEC_SPI     = 16'h004B,
    parameter logic [15:0] VEC_TWOWIRE = 16'h0043
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,

    // APB slave port
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [IRQF_ADDR_W-1:0] paddr,
    input  wire logic [IRQF_DATA_W-1:0] pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [IRQF_DATA_W-1:0] prdata,
    output logic                        pready,
    output logic                        pslverr,

    // Event strobes and levels from the peripherals
    input  wire logic                   timer0_overflow,
    input  wire logic                   timer1_overflow,

    input  wire logic                   ext_irq0_pin,
    input  wire logic                   ext_irq1_pin,

    input  wire logic                   uart_mode0,
    input  wire logic                   uart_tx_bit8_end,
    input  wire logic                   uart_tx_stop_begin,
    input  wire logic                   uart_rx_bit8_end,
    input  wire logic                   uart_rx_stop_mid,

    input  wire logic                   spi_xfer_end,
    input  wire logic                   spi_fault_event,
    input  wire logic                   spi_data_reg_read,

    input  wire logic [7:0]             twowire_state,
    input  wire logic                   twowire_state_enter,

    input  wire logic                   adc_pending,

    // Processor side: combined request and vector, and the event line
    output logic                        irq_req,
    output logic      [IRQF_VEC_W-1:0]  irq_vector,
    output logic                        irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Registers sit on word addresses, so the two low address bits must be zero
    function automatic logic addr_is(input logic [IRQF_ADDR_W-1:0] a,
                                     input logic [IRQF_IDX_W-1:0]  idx);
        addr_is = (a == {idx, 2'b00});
    endfunction

    // Later tests override earlier ones: the last line has the top priority
    function automatic logic [IRQF_VEC_W-1:0] pick_vector(input logic [IRQF_NSRC-1:0] p);
        pick_vector = VEC_RESET;
        if (p[SRC_ADC])     pick_vector = VEC_ADC;
        if (p[SRC_TWOWIRE]) pick_vector = VEC_TWOWIRE;
        if (p[SRC_SPI])     pick_vector = VEC_SPI;
        if (p[SRC_UART])    pick_vector = VEC_UART;
        if (p[SRC_TIMER1])  pick_vector = VEC_TIMER1;
        if (p[SRC_EXT1])    pick_vector = VEC_EXT1;
        if (p[SRC_TIMER0])  pick_vector = VEC_TIMER0;
        if (p[SRC_EXT0])    pick_vector = VEC_EXT0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    // Software-visible flags and the internal SPI clear arm
    logic                timer1_pending;
    logic                timer0_pending;
    logic                ext_irq1_pending;
    logic                ext_irq0_pending;
    logic                uart_tx_done;
    logic                uart_rx_done;
    logic                spi_xfer_done;
    logic                spi_mode_fault;
    logic                spi_clear_armed;
    logic                twowire_flag;

    // Enable, sticky event status and its mask
    logic [7:0]          irq_enable;
    logic [7:0]          event_status;
    logic [7:0]          event_mask;

    // Pin synchronisers and the filtered pin level
    logic [2:0]          ext0_sync;
    logic [2:0]          ext1_sync;
    logic                ext0_level;
    logic                ext1_level;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    // Every strobe is qualified by the access phase
    wire access     = psel & penable;
    wire wr_access  = access & pwrite & pstrb[0];
    wire rd_access  = access & ~pwrite;
    wire hit_timer  = addr_is(paddr, IDX_TIMER_EXT_IRQ_FLAGS);
    wire hit_serial = addr_is(paddr, IDX_SERIAL_PORT_CONTROL);
    wire hit_tw     = addr_is(paddr, IDX_TWOWIRE_CONTROL);
    wire hit_spi    = addr_is(paddr, IDX_SPI_STATUS);
    wire hit_enable = addr_is(paddr, IDX_IRQ_ENABLE);
    wire hit_status = addr_is(paddr, IDX_EVENT_STATUS);
    wire hit_mask   = addr_is(paddr, IDX_EVENT_MASK);
    wire hit_info   = addr_is(paddr, IDX_REQUEST_INFO);
    wire hit_any    = hit_timer | hit_serial | hit_tw | hit_spi
                    | hit_enable | hit_status | hit_mask | hit_info;

    // Write and read strobes per register
    wire wr_timer   = wr_access & hit_timer;
    wire wr_serial  = wr_access & hit_serial;
    wire wr_tw      = wr_access & hit_tw;
    wire wr_enable  = wr_access & hit_enable;
    wire wr_mask    = wr_access & hit_mask;
    wire rd_spi     = rd_access & hit_spi;
    wire rd_status  = rd_access & hit_status;
    wire [7:0] wbyte = pwdata[7:0];

    // Zero wait states; bad addresses answer with an error and change nothing
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;

    ////////////////////////////////////////////////////////////////////////////
    // Event sources

    wire ext0_pin_in = ext_irq0_pin;
    wire ext1_pin_in = ext_irq1_pin;

    // External pins: three stages, a fall counts once stages two and three agree
    wire ext0_fall = ext0_level & (ext0_sync[1] == ext0_sync[2]) & ~ext0_sync[2];
    wire ext1_fall = ext1_level & (ext1_sync[1] == ext1_sync[2]) & ~ext1_sync[2];

    // The mode picks which strobe counts; the other one is ignored
    wire tx_event  = uart_mode0 ? uart_tx_bit8_end : uart_tx_stop_begin;
    wire rx_event  = uart_mode0 ? uart_rx_bit8_end : uart_rx_stop_mid;

    // The no-information state is seen but raises nothing
    wire tw_event  = twowire_state_enter
                   & (twowire_state != TW_NO_INFO_STATE);

    ////////////////////////////////////////////////////////////////////////////
    // Next values; a hardware set always beats a same-cycle clear

    wire next_timer1 = timer1_overflow
                     | (wr_timer ? wbyte[BIT_TIMER1] : timer1_pending);

    wire next_timer0 = timer0_overflow
                     | (wr_timer ? wbyte[BIT_TIMER0] : timer0_pending);

    wire next_ext1   = ext1_fall
                     | (wr_timer ? wbyte[BIT_EXT1] : ext_irq1_pending);

    wire next_ext0   = ext0_fall
                     | (wr_timer ? wbyte[BIT_EXT0] : ext_irq0_pending);

    // Hardware only sets these; the only clear is a software write
    wire next_tx     = tx_event
                     | (wr_serial ? wbyte[BIT_UART_TX] : uart_tx_done);

    wire next_rx     = rx_event
                     | (wr_serial ? wbyte[BIT_UART_RX] : uart_rx_done);

    // A written one is ignored, a written zero clears
    wire tw_clear    = wr_tw & ~wbyte[BIT_TW_FLAG];
    wire next_tw     = tw_event | (twowire_flag & ~tw_clear);

    // Clear needs a status read first; a new completion disarms it so the
    // following data read cannot swallow a flag software has not yet seen
    wire spi_clear       = spi_clear_armed & spi_data_reg_read;
    wire next_spi_done   = spi_xfer_end | (spi_xfer_done & ~spi_clear);
    wire next_spi_armed  = ~spi_xfer_end & ~spi_clear
                         & (spi_clear_armed | (rd_spi & prdata[BIT_SPI_DONE]));

    // Bits are judged by what the read returned, latched in setup, so a flag
    // raised between setup and access is never cleared unseen
    wire next_spi_fault  = spi_fault_event
                         | (spi_mode_fault & ~(rd_spi & prdata[BIT_SPI_FAULT]));

    ////////////////////////////////////////////////////////////////////////////
    // Sticky event status, read to clear, set wins

    wire [7:0] src_event;
    assign src_event[SRC_EXT0]    = ext0_fall;
    assign src_event[SRC_TIMER0]  = timer0_overflow;
    assign src_event[SRC_EXT1]    = ext1_fall;
    assign src_event[SRC_TIMER1]  = timer1_overflow;
    assign src_event[SRC_UART]    = tx_event | rx_event;
    assign src_event[SRC_SPI]     = spi_xfer_end;
    assign src_event[SRC_TWOWIRE] = tw_event;
    assign src_event[SRC_ADC]     = adc_pending;

    // Only the bits that the read returned are cleared
    wire [7:0] status_clr = rd_status ? prdata[IRQF_REG_W-1:0] : REG_RESET;

    wire [7:0] next_event_status;
    genvar gi;
    generate
        for (gi = 0; gi < IRQF_NSRC; gi++) begin : g_sticky
            assign next_event_status[gi] = src_event[gi]
                                         | (event_status[gi] & ~status_clr[gi]);
        end
    endgenerate

    // Level output: high while an unmasked event bit is set
    assign irq_out = |(event_status & event_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Request combining and vector selection

    // Both UART flags share one source; the converter request is a level
    wire [7:0] flag_pending;
    assign flag_pending[SRC_EXT0]    = ext_irq0_pending;
    assign flag_pending[SRC_TIMER0]  = timer0_pending;
    assign flag_pending[SRC_EXT1]    = ext_irq1_pending;
    assign flag_pending[SRC_TIMER1]  = timer1_pending;
    assign flag_pending[SRC_UART]    = uart_tx_done | uart_rx_done;
    assign flag_pending[SRC_SPI]     = spi_xfer_done;
    assign flag_pending[SRC_TWOWIRE] = twowire_flag;
    assign flag_pending[SRC_ADC]     = adc_pending;

    wire [7:0]  gated_pending = flag_pending & irq_enable;
    wire        next_req      = |gated_pending;

    // Without a request the vector reads as the reset fetch address
    wire [15:0] next_vector   = pick_vector(gated_pending);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, latched in the setup phase

    wire [7:0] rd_timer  = (8'(timer1_pending)   << BIT_TIMER1)
                         | (8'(timer0_pending)   << BIT_TIMER0)
                         | (8'(ext_irq1_pending) << BIT_EXT1)
                         | (8'(ext_irq0_pending) << BIT_EXT0);

    wire [7:0] rd_serial = (8'(uart_tx_done) << BIT_UART_TX)
                         | (8'(uart_rx_done) << BIT_UART_RX);

    wire [7:0] rd_tw     = 8'(twowire_flag) << BIT_TW_FLAG;

    wire [7:0] rd_spist  = (8'(spi_xfer_done)  << BIT_SPI_DONE)
                         | (8'(spi_mode_fault) << BIT_SPI_FAULT);

    wire [7:0] rd_byte   = hit_timer  ? rd_timer     :
                           hit_serial ? rd_serial    :
                           hit_tw     ? rd_tw        :
                           hit_spi    ? rd_spist     :
                           hit_enable ? irq_enable   :
                           hit_status ? event_status :
                           hit_mask   ? event_mask   : REG_RESET;

    // The info word mirrors the request that the core sees
    wire [31:0] rd_word  = hit_info ? {irq_vector, 7'h00, irq_req, gated_pending}
                                    : {24'h00_0000, rd_byte};

    // Loaded in setup so that it stands through the whole access phase
    wire        setup    = psel & ~penable;

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Synchronisers reset high, the idle pin level, so reset makes no false edge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext0_sync  <= 3'h7;
            ext1_sync  <= 3'h7;
            ext0_level <= 1'b1;
            ext1_level <= 1'b1;
        end else begin
            ext0_sync  <= {ext0_sync[1:0], ext0_pin_in};
            ext1_sync  <= {ext1_sync[1:0], ext1_pin_in};
            if (ext0_sync[1] == ext0_sync[2]) ext0_level <= ext0_sync[2];
            if (ext1_sync[1] == ext1_sync[2]) ext1_level <= ext1_sync[2];
        end
    end

    // Timer and pin flags
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer1_pending   <= 1'b0;
            timer0_pending   <= 1'b0;
            ext_irq1_pending <= 1'b0;
            ext_irq0_pending <= 1'b0;
        end else begin
            timer1_pending   <= next_timer1;
            timer0_pending   <= next_timer0;
            ext_irq1_pending <= next_ext1;
            ext_irq0_pending <= next_ext0;
        end
    end

    // Serial, two-wire and SPI flags
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            uart_tx_done     <= 1'b0;
            uart_rx_done     <= 1'b0;
            twowire_flag     <= 1'b0;
            spi_xfer_done    <= 1'b0;
            spi_clear_armed  <= 1'b0;
            spi_mode_fault   <= 1'b0;
        end else begin
            uart_tx_done     <= next_tx;
            uart_rx_done     <= next_rx;
            twowire_flag     <= next_tw;
            spi_xfer_done    <= next_spi_done;
            spi_clear_armed  <= next_spi_armed;
            spi_mode_fault   <= next_spi_fault;
        end
    end

    // Enable and mask are plain read-write bytes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_enable   <= REG_RESET;
            event_mask   <= REG_RESET;
            event_status <= REG_RESET;
        end else begin
            if (wr_enable) irq_enable <= wbyte;
            if (wr_mask)   event_mask <= wbyte;
            event_status <= next_event_status;
        end
    end

    // Request and vector to the core, registered so they never glitch
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_req    <= 1'b0;
            irq_vector <= VEC_RESET;
        end else begin
            irq_req    <= next_req;
            irq_vector <= next_vector;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= RDATA_ZERO;
        end else if (setup && !pwrite) begin
            prdata <= rd_word;
        end
    end

endmodule
`default_nettype wire
